// ===== hdl/twm_pkg.sv
// constants, field layout and types for the two-wire master controller
// assumes a 125 MHz system clock and a register port with one-cycle read latency
package twm_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam int unsigned AW          = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_MODE    = 8'h04;
    localparam logic [7:0]  OFF_CLKD    = 8'h08;
    localparam logic [7:0]  OFF_STAT    = 8'h0C;
    localparam logic [7:0]  OFF_RHR     = 8'h10;
    localparam logic [7:0]  OFF_THR     = 8'h14;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned CTRL_START  = 0;
    localparam int unsigned CTRL_MSEN   = 2;
    localparam int unsigned CTRL_HALT   = 3;
    localparam int unsigned CTRL_SWRST  = 7;
    localparam int unsigned MODE_DADR   = 0;
    localparam int unsigned MODE_READ   = 12;
    localparam int unsigned CLKD_LOW    = 0;
    localparam int unsigned CLKD_HIGH   = 8;
    localparam int unsigned CLKD_EXP    = 16;
    localparam int unsigned ST_DONE     = 0;
    localparam int unsigned ST_RX_READY = 1;
    localparam int unsigned ST_TX_READY = 2;
    localparam int unsigned ST_OVRE     = 6;
    localparam int unsigned ST_NACK     = 8;

    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int unsigned DIV_W       = 8;
    localparam int unsigned EXP_W       = 3;
    localparam int unsigned TMR_W       = 13;
    localparam int unsigned BITS_BYTE   = 8;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [7:0]  DIV_RST     = 8'h00;
    localparam logic [2:0]  EXP_RST     = 3'h0;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic nack;
        logic ovre;
        logic tx_ready;
        logic rx_ready;
        logic done;
    } twm_stat_t;

    localparam twm_stat_t STAT_RST = '{nack: 1'b0, ovre: 1'b0, tx_ready: 1'b1,
                                       rx_ready: 1'b0, done: 1'b1};

    typedef struct packed {
        logic scl;
        logic sda;
    } twm_line_t;

    typedef enum {S_IDLE, S_START, S_BIT, S_STOP} twm_state_t;

endpackage : twm_pkg

// ===== hdl/twm_sync.sv
// two-stage synchroniser for the sampled bus lines
// assumes the inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module twm_sync
    import twm_pkg::*;
#(
    parameter int unsigned W = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    initial begin
        if (W < 1) $error("twm_sync width must be at least 1");
    end

    // first stage feeds only the second
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : twm_sync

// ===== hdl/twm_master.sv
// two-wire bus master controller, register port on one side, open-drain pins on the other
// assumes external pull-ups and a register master that never holds both strobes at once
//
// Contract
// - soft reset mid-frame with clock low blocks every later transfer
// - writing master-disable freezes a running transfer at once
// - disabling leaves transfer-complete and transmit-ready flags untouched
// - status read between nack detection and frame end loses the nack flag
// - nack and transfer-complete rise together; status read clears nack
// - every byte loads the receive holding register, transmit bytes too
// - transmit-byte overwrite of receive holding raises neither ready nor overrun
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module twm_master
    import twm_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    input  wire logic          scl_in,
    output logic               scl_out,
    output logic               scl_oe,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    twm_state_t         state,    next_state;
    twm_stat_t          st,       next_st;
    twm_line_t          line_s;
    logic               en,       next_en;
    logic               stuck,    next_stuck;
    logic [6:0]         dadr,     next_dadr;
    logic               rd_dir,   next_rd_dir;
    logic [DIV_W-1:0]   low_div,  next_low_div;
    logic [DIV_W-1:0]   high_div, next_high_div;
    logic [EXP_W-1:0]   div_exp,  next_div_exp;
    logic [7:0]         rhr,      next_rhr;
    logic [7:0]         thr,      next_thr;
    logic [7:0]         shift,    next_shift;
    logic [3:0]         bitn,     next_bitn;
    logic               hi,       next_hi;
    logic               rx_byte,  next_rx_byte;
    logic               nack_pend, next_nack_pend;
    logic [TMR_W-1:0]   tmr,      next_tmr;
    logic               scl_low,  next_scl_low;
    logic               sda_low,  next_sda_low;
    logic [31:0]        next_rdata;
    logic               wr_ctrl;
    logic               swrst;
    logic               tick;
    logic               byte_end;
    logic               stop_end;

    // phase length in system clocks; counter is only 13 bits wide
    function automatic logic [TMR_W-1:0] phase_len(input logic [DIV_W-1:0] d,
                                                   input logic [EXP_W-1:0] e);
        logic [DIV_W+7:0] full;
        full = {8'h00, d} << e;
        return full[TMR_W-1:0];
    endfunction : phase_len

    twm_sync #(.W($bits(twm_line_t))) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     ({scl_in, sda_in}),
        .dout    (line_s)
    );

    // open drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_low;
    assign sda_oe  = sda_low;
    assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
    assign swrst   = wr_ctrl && reg_wdata[CTRL_SWRST];
    assign tick    = (tmr == '0);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        next_state = state;        next_st = st;           next_en = en;
        next_stuck = stuck;        next_dadr = dadr;       next_rd_dir = rd_dir;
        next_low_div = low_div;    next_high_div = high_div;
        next_div_exp = div_exp;    next_rhr = rhr;         next_thr = thr;
        next_shift = shift;        next_bitn = bitn;       next_hi = hi;
        next_rx_byte = rx_byte;    next_nack_pend = nack_pend;
        next_tmr = tmr;            next_scl_low = scl_low; next_sda_low = sda_low;
        next_rdata = 32'h0000_0000;
        byte_end = 1'b0;
        stop_end = 1'b0;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL: begin
                    if (reg_wdata[CTRL_MSEN]) next_en = 1'b1;
                    if (reg_wdata[CTRL_HALT]) next_en = 1'b0;
                end
                OFF_MODE: begin
                    next_dadr   = reg_wdata[MODE_DADR +: 7];
                    next_rd_dir = reg_wdata[MODE_READ];
                end
                OFF_CLKD: begin
                    next_low_div  = reg_wdata[CLKD_LOW +: DIV_W];
                    next_high_div = reg_wdata[CLKD_HIGH +: DIV_W];
                    next_div_exp  = reg_wdata[CLKD_EXP +: EXP_W];
                end
                OFF_THR: begin
                    next_thr         = reg_wdata[7:0];
                    next_st.tx_ready = 1'b0;
                end
                default: ;
            endcase
        end

        // register reads and their side effects
        if (reg_rd) begin
            case (reg_addr)
                OFF_MODE: begin
                    next_rdata[MODE_DADR +: 7] = dadr;
                    next_rdata[MODE_READ]      = rd_dir;
                end
                OFF_CLKD: begin
                    next_rdata[CLKD_LOW +: DIV_W]  = low_div;
                    next_rdata[CLKD_HIGH +: DIV_W] = high_div;
                    next_rdata[CLKD_EXP +: EXP_W]  = div_exp;
                end
                OFF_STAT: begin
                    next_rdata[ST_DONE]     = st.done;
                    next_rdata[ST_RX_READY] = st.rx_ready;
                    next_rdata[ST_TX_READY] = st.tx_ready;
                    next_rdata[ST_OVRE]     = st.ovre;
                    next_rdata[ST_NACK]     = st.nack;
                    next_st.nack   = 1'b0;
                    next_st.ovre   = 1'b0;
                    next_nack_pend = 1'b0;
                end
                OFF_RHR: begin
                    next_rdata[7:0]  = rhr;
                    next_st.rx_ready = 1'b0;
                end
                default: ;
            endcase
        end

        // frame start
        if (wr_ctrl && reg_wdata[CTRL_START] && next_en && !stuck && state == S_IDLE) begin
            next_state     = S_START;
            next_shift     = {dadr, rd_dir};
            next_st.done   = 1'b0;
            next_nack_pend = 1'b0;
            next_rx_byte   = 1'b0;
            next_sda_low   = 1'b1;
            next_hi        = 1'b1;
            next_tmr       = phase_len(high_div, div_exp);
        end else if (next_en && state != S_IDLE) begin
            // high phase waits for the line to really rise (stretching)
            if (!tick && !(hi && !line_s.scl)) next_tmr = tmr - 1'b1;
            case (state)
                S_START: if (tick) begin
                    next_state   = S_BIT;
                    next_scl_low = 1'b1;
                    next_hi      = 1'b0;
                    next_bitn    = 4'h0;
                    next_sda_low = !shift[7];
                    next_tmr     = phase_len(low_div, div_exp);
                end
                S_BIT: if (tick) begin
                    if (!hi) begin
                        next_scl_low = 1'b0;
                        next_hi      = 1'b1;
                        next_tmr     = phase_len(high_div, div_exp);
                    end else begin
                        next_scl_low = 1'b1;
                        next_hi      = 1'b0;
                        next_tmr     = phase_len(low_div, div_exp);
                        if (bitn < 4'(BITS_BYTE)) begin
                            next_shift   = {shift[6:0], line_s.sda};
                            next_bitn    = bitn + 1'b1;
                            // ack slot released; reads always answer nack
                            next_sda_low = (bitn == 4'(BITS_BYTE - 1)) ? 1'b0
                                         : (!rx_byte && !shift[6]);
                        end else begin
                            byte_end  = 1'b1;
                            next_rhr  = shift;
                            next_bitn = 4'h0;
                            if (rx_byte) begin
                                next_st.rx_ready = 1'b1;
                                next_st.ovre     = st.rx_ready || next_st.ovre;
                                next_state    = S_STOP;
                                next_sda_low  = 1'b1;
                            end else if (line_s.sda) begin
                                next_nack_pend = 1'b1;
                                next_state     = S_STOP;
                                next_sda_low   = 1'b1;
                            end else if (rd_dir) begin
                                next_rx_byte = 1'b1;
                                next_sda_low = 1'b0;
                            end else if (!st.tx_ready) begin
                                // overwritten rhr raises no flag here
                                next_shift       = thr;
                                next_st.tx_ready = 1'b1;
                                next_sda_low  = !thr[7];
                            end else begin
                                next_state   = S_STOP;
                                next_sda_low = 1'b1;
                            end
                        end
                    end
                end
                S_STOP: if (tick) begin
                    if (!hi) begin
                        next_scl_low = 1'b0;
                        next_hi      = 1'b1;
                        next_tmr     = phase_len(high_div, div_exp);
                    end else begin
                        stop_end       = 1'b1;
                        next_sda_low   = 1'b0;
                        next_state     = S_IDLE;
                        next_st.done   = 1'b1;
                        next_st.nack   = nack_pend;
                    end
                end
                default: next_state = S_IDLE;
            endcase
        end

        // soft reset; a frame cut with the clock low wedges the master
        if (swrst) begin
            if (state != S_IDLE && scl_low) next_stuck = 1'b1;
            next_state = S_IDLE;   next_st = STAT_RST;      next_en = 1'b0;
            next_scl_low = 1'b0;   next_sda_low = 1'b0;     next_hi = 1'b0;
            next_tmr = '0;         next_bitn = 4'h0;        next_nack_pend = 1'b0;
            next_rx_byte = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;   st <= STAT_RST;      en <= 1'b0;      stuck <= 1'b0;
            dadr <= 7'h00;     rd_dir <= 1'b0;      low_div <= DIV_RST;
            high_div <= DIV_RST; div_exp <= EXP_RST; rhr <= 8'h00;   thr <= 8'h00;
            shift <= 8'h00;    bitn <= 4'h0;        hi <= 1'b0;      rx_byte <= 1'b0;
            nack_pend <= 1'b0; tmr <= '0;           scl_low <= 1'b0; sda_low <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;   st <= next_st;           en <= next_en;
            stuck <= next_stuck;   dadr <= next_dadr;       rd_dir <= next_rd_dir;
            low_div <= next_low_div; high_div <= next_high_div; div_exp <= next_div_exp;
            rhr <= next_rhr;       thr <= next_thr;         shift <= next_shift;
            bitn <= next_bitn;     hi <= next_hi;           rx_byte <= next_rx_byte;
            nack_pend <= next_nack_pend; tmr <= next_tmr;
            scl_low <= next_scl_low; sda_low <= next_sda_low;
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_stuck_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
        stuck && state == S_IDLE |=> (state == S_IDLE) [*3])
        else $error("frame started after wedging soft reset");
    a_disable_freeze: assert property (@(posedge clk_sys) disable iff (!rstn)
        !en && !wr_ctrl |=> $stable(state) && $stable(tmr) && $stable(scl_oe) && $stable(sda_oe))
        else $error("disabled master moved");
    a_disable_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_ctrl && reg_wdata[CTRL_HALT] && !swrst
        |=> st.done == $past(st.done) && st.tx_ready == $past(st.tx_ready))
        else $error("disable changed completion or ready flag");
    a_nack_lost: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == OFF_STAT && state == S_STOP |=> !nack_pend)
        else $error("status read did not drop pending nack");
    a_nack_with_done: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(st.nack) |-> $rose(st.done))
        else $error("nack rose without completion");
    a_read_clears_nack: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == OFF_STAT && !stop_end |=> !st.nack)
        else $error("status read left nack set");
    a_rhr_any_dir: assert property (@(posedge clk_sys) disable iff (!rstn)
        byte_end |=> rhr == $past(shift))
        else $error("holding register not loaded at byte end");
    a_tx_no_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
        byte_end && !rx_byte && !st.rx_ready && !st.ovre |=> !st.rx_ready && !st.ovre)
        else $error("transmit byte raised receive flag");
    a_nack_stops: assert property (@(posedge clk_sys) disable iff (!rstn)
        byte_end && !rx_byte && line_s.sda |=> state == S_STOP && nack_pend)
        else $error("missing acknowledge did not end frame");

endmodule : twm_master

// ===== verification/twm_slave_model.sv
// behavioural slave on the two-wire bus, answers the master in the bench
// assumes pull-ups on both lines and clk_sys far faster than the bus clock
`timescale 1ns/1ps
module twm_slave_model (
    input  wire logic       clk_sys,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic [7:0] rd_byte,
    output logic            sda_oe,
    output logic [7:0]      got0,
    output logic [7:0]      got1,
    output int              bitc,
    output int              frames,
    output int              slots
);
    logic       scl_q = 1'b1;
    logic       sda_q = 1'b1;
    logic       rd    = 1'b0;
    logic       send  = 1'b0;
    logic [7:0] sh    = 8'h00;
    int         idx   = 0;

    // ----------------------------------------
    // line watcher
    // ----------------------------------------
    // sampled mid-cycle so a same-edge change of both lines reads as a clock edge
    initial begin
        sda_oe = 1'b0;
        bitc = 0;
        frames = 0;
        slots = 0;
        got0 = 8'h00;
        got1 = 8'h00;
    end

    always @(negedge clk_sys) begin
        if (scl && scl_q && sda_q && !sda) begin
            bitc = 0;
            idx = 0;
            send = 1'b0;
            sda_oe = 1'b0;
        end else if (scl && scl_q && !sda_q && sda) begin
            frames = frames + 1;
            sda_oe = 1'b0;
        end else if (scl && !scl_q) begin
            if (bitc < 8) begin
                sh = {sh[6:0], sda};
                bitc = bitc + 1;
            end
        end else if (!scl && scl_q) begin
            if (bitc == 8) begin
                if (!send && idx == 0) begin
                    got0 = sh;
                    rd = sh[0];
                end else if (!send) begin
                    got1 = sh;
                end
                sda_oe = !send && ack_en;
                bitc = 9;
            end else if (bitc == 9) begin
                slots = slots + 1;
                send = rd && (idx == 0);
                idx = idx + 1;
                bitc = 0;
                sda_oe = send && !rd_byte[7];
            end else if (send) begin
                sda_oe = !rd_byte[7-bitc];
            end
        end
        scl_q = scl;
        sda_q = sda;
    end
endmodule : twm_slave_model

// ===== verification/test_twm_master.sv
// self-checking bench for the two-wire master: register tasks and a slave model
// assumes the register map and status layout of twm_pkg
`timescale 1ns/1ps
module test_twm_master
    import twm_pkg::*;
;
    logic          clk_sys;
    logic          rstn;
    logic [AW-1:0] reg_addr;
    logic [31:0]   reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [31:0]   reg_rdata;
    logic          scl_out;
    logic          scl_oe;
    logic          sda_out;
    logic          sda_oe;
    logic          s_sda_oe;
    logic          ack_en;
    logic          sv_scl;
    logic          sv_sda;
    logic [7:0]    got0;
    logic [7:0]    got1;
    int            bitc;
    int            frames;
    int            slots;
    int            err_total;
    int            comparisons;
    wire           scl_w;
    wire           sda_w;

    // open drain with pull-ups: any enabled party pulls low
    assign scl_w = !(scl_oe && !scl_out);
    assign sda_w = !((sda_oe && !sda_out) || s_sda_oe);

    twm_master dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe));

    twm_slave_model part_u (.clk_sys(clk_sys), .scl(scl_w), .sda(sda_w), .ack_en(ack_en),
        .rd_byte(8'h3C), .sda_oe(s_sda_oe), .got0(got0), .got1(got1), .bitc(bitc),
        .frames(frames), .slots(slots));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic summarize();
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask : rd

    task automatic go(input logic [31:0] mode);
        wr(OFF_MODE, mode);
        wr(OFF_CTRL, 32'h0000_0005);
    endtask : go

    // bus events seen by the slave: a finished frame, or with use_slots an ended ack slot so status can be polled mid-frame
    task automatic wait_cnt(input bit use_slots);
        int n;
        n = use_slots ? slots : frames;
        for (int i = 0; i < 6000 && n == (use_slots ? slots : frames); i++) @(posedge clk_sys);
        if (n == (use_slots ? slots : frames)) begin
            err_total++;
            summarize();
        end
    endtask : wait_cnt

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ack_en = 1'b1;
        err_total = 0;
        comparisons = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(OFF_STAT, 32'h0000_0005);
        rd(8'h18, 32'h0000_0000);
        chk({30'h0, scl_out, sda_out}, 32'h0000_0000);
        wr(OFF_CLKD, 32'h0000_0709);
        rd(OFF_CLKD, 32'h0000_0709);
        go(32'h0000_1050);
        wait_cnt(1'b0);
        rd(OFF_STAT, 32'h0000_0007);
        chk({24'h0, got0}, 32'h0000_00A1);
        rd(OFF_RHR, 32'h0000_003C);
        wr(OFF_THR, 32'h0000_00A5);
        go(32'h0000_0050);
        wait_cnt(1'b0);
        chk({16'h0, got0, got1}, 32'h0000_A0A5);
        rd(OFF_STAT, 32'h0000_0005);
        rd(OFF_RHR, 32'h0000_00A5);
        ack_en <= 1'b0;
        go(32'h0000_0050);
        wait_cnt(1'b0);
        wr(OFF_CTRL, 32'h0000_0008);
        rd(OFF_STAT, 32'h0000_0105);
        rd(OFF_STAT, 32'h0000_0005);
        go(32'h0000_0050);
        wait_cnt(1'b1);
        rd(OFF_STAT, 32'h0000_0004);
        wait_cnt(1'b0);
        rd(OFF_STAT, 32'h0000_0005);
        // freeze while the clock line is held low
        ack_en <= 1'b1;
        wr(OFF_THR, 32'h0000_005A);
        go(32'h0000_0050);
        for (int i = 0; i < 3000 && !(bitc >= 3 && scl_oe === 1'b1); i++) @(negedge clk_sys);
        if (!(bitc >= 3 && scl_oe === 1'b1)) begin
            err_total++;
            summarize();
        end
        wr(OFF_CTRL, 32'h0000_0008);
        @(negedge clk_sys);
        sv_scl = scl_oe;
        sv_sda = sda_oe;
        chk({31'h0, sv_scl}, 32'h0000_0001);
        repeat (100) begin
            @(negedge clk_sys);
            chk({30'h0, scl_oe, sda_oe}, {30'h0, sv_scl, sv_sda});
        end
        rd(OFF_STAT, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0080);
        rd(OFF_STAT, 32'h0000_0005);
        go(32'h0000_0050);
        repeat (300) begin
            @(negedge clk_sys);
            chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
        end
        rd(OFF_STAT, 32'h0000_0005);
        summarize();
    end
endmodule : test_twm_master
